// ### design/cdp_host.sv
// Contract
// - Request low: host starts no new transfer.
// - After request high host may send up to 32 bytes unchecked.
// - Request is checked only before starting; a running transfer is never aborted.
// - Commands sent while request low need a worst-case delay after each.
// - Host generates the stream bit clock.
// - Host keeps data select stable while a stream byte shifts.
// - Host periodically toggles data select to realign bytes; the code toggles it after every byte, and no select in shared mode.
// - Command bits sampled rising, changed falling, MSB first, select low throughout.
// - Request low after each command; wait for high before next transfer.
// - On read device shifts 16-bit value out; host then raises select.
// - Host serial clock at most one seventh of device internal clock.
// - Host raises command select between commands and respects request.
// Purpose: Host controller driving command and stream ports of a serial decoder
// Assumes: APB slave, device internal clock rate sets the bit timing
// Notes:   Serial clock is driven by a divider of core_clk
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cdp_host
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // APB
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Device pins
    output logic                      command_select_n,
    output logic                      data_select_n,
    output logic                      serial_clock,
    output logic                      serial_out,
    input  wire logic                 serial_in,
    input  wire logic                 data_request,
    // Mode seen by the bus
    output logic                      busy
);
    import cdp_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic       req_s1_reg;
    logic       req_s2_reg;
    logic       sin_s1_reg;
    logic       sin_s2_reg;
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            sin_s1_reg <= 1'b0;
            sin_s2_reg <= 1'b0;
        end
        else
        begin
            req_s1_reg <= data_request;
            req_s2_reg <= req_s1_reg;
            sin_s1_reg <= serial_in;
            sin_s2_reg <= sin_s1_reg;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0]   ctrl_reg;
    logic [15:0]   cmd_reg;
    logic [15:0]   wdata_reg;
    logic [15:0]   rdata_reg;
    logic          rdone_reg;
    logic [7:0]    sbyte_reg;
    logic          sfull_reg;
    logic          go_cmd_reg;
    logic          is_cmd_reg;
    logic [7:0]    sbyte_rev;
    logic [31:0]   shift_reg;
    logic [5:0]    bits_reg;
    logic [7:0]    tick_reg;
    logic          capture_reg;
    logic          start_cmd;
    logic          start_byte;
    logic          frame_end;
    cdp_state_type state_reg;

    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;

    // Bit-reversed stream byte for LSB-first order
    for (genvar k = 0; k < 8; k++)
    begin : g_rev
        assign sbyte_rev[k] = sbyte_reg[7 - k];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            ctrl_reg   <= CDP_CTRL_RESET;
            cmd_reg    <= 16'h0000;
            wdata_reg  <= 16'h0000;
            go_cmd_reg <= 1'b0;
            sbyte_reg  <= 8'h00;
            sfull_reg  <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == CDP_OFF_CTRL)
                ctrl_reg <= pwdata;
            if (wr_acc && paddr == CDP_OFF_WDATA)
                wdata_reg <= pwdata[15:0];
            if (wr_acc && paddr == CDP_OFF_CMD && !go_cmd_reg)
            begin
                cmd_reg    <= pwdata[15:0];
                go_cmd_reg <= 1'b1;
            end
            else if (start_cmd)
                go_cmd_reg <= 1'b0;
            if (wr_acc && paddr == CDP_OFF_STREAM && !sfull_reg)
            begin
                sbyte_reg <= pwdata[7:0];
                sfull_reg <= 1'b1;
            end
            else if (start_byte)
                sfull_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > CDP_OFF_STATUS;
            case (paddr)
                CDP_OFF_CTRL:   prdata <= ctrl_reg;
                CDP_OFF_CMD:    prdata <= {16'h0000, cmd_reg};
                CDP_OFF_WDATA:  prdata <= {16'h0000, wdata_reg};
                CDP_OFF_RDATA:  prdata <= {16'h0000, rdata_reg};
                CDP_OFF_STATUS: prdata <= {28'h000_0000, rdone_reg, sfull_reg,
                                           req_s2_reg, busy};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************
    // Serial engine
    // ****************************************
    // Only start a transfer when request is high; request is checked before every stream byte
    assign start_cmd  = state_reg == CDP_WAITREQ && is_cmd_reg && req_s2_reg;
    assign start_byte = state_reg == CDP_WAITREQ && !is_cmd_reg && req_s2_reg;
    assign frame_end  = state_reg == CDP_HIGH && tick_reg == 8'(CDP_HALF_CYC - 1)
                        && bits_reg == 6'd1;

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg        <= CDP_IDLE;
            is_cmd_reg       <= 1'b0;
            shift_reg        <= 32'h0000_0000;
            bits_reg         <= 6'd0;
            tick_reg         <= 8'd0;
            command_select_n <= 1'b1;
            data_select_n    <= 1'b1;
            serial_clock     <= 1'b0;
            serial_out       <= 1'b0;
            busy             <= 1'b0;
        end
        else
        begin
            case (state_reg)
                CDP_IDLE:
                begin
                    busy <= go_cmd_reg || sfull_reg;
                    if (go_cmd_reg)
                    begin
                        is_cmd_reg <= 1'b1;
                        state_reg  <= CDP_WAITREQ;
                    end
                    else if (sfull_reg)
                    begin
                        is_cmd_reg <= 1'b0;
                        state_reg  <= CDP_WAITREQ;
                    end
                end
                CDP_WAITREQ:
                begin
                    tick_reg <= 8'd0;
                    if (start_cmd)
                    begin
                        // Opcode, address and data, MSB first
                        shift_reg <= {cmd_reg[CDP_CMD_WRITE] ? CDP_OP_WRITE : CDP_OP_READ,
                                      cmd_reg[7:0], wdata_reg};
                        bits_reg  <= 6'd32;
                        command_select_n <= 1'b0;
                        state_reg <= CDP_LOW;
                    end
                    else if (start_byte)
                    begin
                        shift_reg <= ctrl_reg[CDP_CTRL_LSBF]
                                   ? {sbyte_rev, 24'h00_0000}
                                   : {sbyte_reg, 24'h00_0000};
                        bits_reg  <= 6'd8;
                        // Shared select: stream framed by command select pin
                        if (ctrl_reg[CDP_CTRL_SHARED])
                            command_select_n <= 1'b1;
                        else
                            data_select_n <= 1'b0;
                        state_reg <= CDP_LOW;
                    end
                end
                CDP_LOW:
                begin
                    serial_out <= shift_reg[31];
                    tick_reg   <= tick_reg + 8'd1;
                    if (tick_reg == 8'(CDP_HALF_CYC - 1))
                    begin
                        tick_reg     <= 8'd0;
                        serial_clock <= 1'b1;
                        state_reg    <= CDP_HIGH;
                    end
                end
                CDP_HIGH:
                begin
                    tick_reg <= tick_reg + 8'd1;
                    if (tick_reg == 8'(CDP_HALF_CYC - 1))
                    begin
                        tick_reg     <= 8'd0;
                        serial_clock <= 1'b0;
                        shift_reg    <= {shift_reg[30:0], 1'b0};
                        bits_reg     <= bits_reg - 6'd1;
                        if (frame_end)
                        begin
                            // Raise selects to end frame and realign bytes
                            command_select_n <= 1'b1;
                            data_select_n    <= 1'b1;
                            state_reg        <= CDP_GAP;
                        end
                        else
                            state_reg <= CDP_LOW;
                    end
                end
                CDP_GAP:
                begin
                    tick_reg <= tick_reg + 8'd1;
                    if (tick_reg == 8'(CDP_GAP_CYC - 1))
                    begin
                        // Stay busy when another job is already queued
                        busy      <= go_cmd_reg || sfull_reg;
                        state_reg <= CDP_IDLE;
                    end
                end
                default:
                    state_reg <= CDP_IDLE;
            endcase
        end
    end

    // ****************************************
    // Read capture on rising serial clock
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            rdata_reg   <= 16'h0000;
            rdone_reg   <= 1'b0;
            capture_reg <= 1'b0;
        end
        else
        begin
            capture_reg <= is_cmd_reg && !cmd_reg[CDP_CMD_WRITE] && state_reg == CDP_LOW
                           && tick_reg == 8'(CDP_HALF_CYC - 1) && bits_reg <= 6'd16;
            // Device shifts on falling edge; sample just before rising edge
            if (capture_reg)
                rdata_reg <= {rdata_reg[14:0], sin_s2_reg};
            if (start_cmd)
                rdone_reg <= 1'b0;
            else if (frame_end && is_cmd_reg && !cmd_reg[CDP_CMD_WRITE])
                rdone_reg <= 1'b1;
        end
    end
endmodule : cdp_host
`default_nettype wire

// ### design/cdp_pkg.sv
// Purpose: Constants for the host-side controller of a serial command and stream port
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Controller registers are of this block's own making
package cdp_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] CDP_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CDP_OFF_CMD    = 8'h04;
    localparam logic [7:0] CDP_OFF_WDATA  = 8'h08;
    localparam logic [7:0] CDP_OFF_RDATA  = 8'h0C;
    localparam logic [7:0] CDP_OFF_STREAM = 8'h10;
    localparam logic [7:0] CDP_OFF_STATUS = 8'h14;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CDP_CTRL_SHARED  = 0;
    localparam int CDP_CTRL_LSBF    = 1;
    localparam int CDP_CMD_WRITE    = 8;
    localparam int CDP_ST_BUSY      = 0;
    localparam int CDP_ST_REQ       = 1;
    localparam int CDP_ST_SFULL     = 2;
    localparam int CDP_ST_RDONE     = 3;
    // ****************************************
    // Protocol constants
    // ****************************************
    localparam logic [7:0] CDP_OP_READ  = 8'h03;
    localparam logic [7:0] CDP_OP_WRITE = 8'h02;
    localparam int CDP_BURST_BYTES      = 32;
    localparam int CDP_CLK_MHZ          = 50;
    localparam int CDP_DEV_CLK_MHZ      = 12;
    localparam int CDP_SCK_DIV          = 7;
    // Half period of serial clock in core cycles, at most device clock / divider
    localparam int CDP_HALF_CYC =
        (CDP_CLK_MHZ * CDP_SCK_DIV + 2 * CDP_DEV_CLK_MHZ - 1) / (2 * CDP_DEV_CLK_MHZ);
    // Gap with select high between frames, core cycles
    localparam int CDP_GAP_CYC = 2 * CDP_HALF_CYC;
    localparam logic [31:0] CDP_CTRL_RESET = 32'h0000_0000;
    typedef enum logic [2:0] {CDP_IDLE, CDP_WAITREQ, CDP_LOW, CDP_HIGH, CDP_GAP} cdp_state_type;
endpackage : cdp_pkg

// ### dv/cdp_host_sva.sv
// Purpose: Assertions on the bus and device pins of the host controller
// Assumes: Bound to cdp_host, one clock domain
// Notes:   Counters measure clock phases and clock edges per frame
`timescale 1ns/1ps
`default_nettype none
module cdp_host_sva
    import cdp_pkg::*;
(
    // Clock, reset and bus
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Device pins
    input wire logic       command_select_n,
    input wire logic       data_select_n,
    input wire logic       serial_clock,
    input wire logic       serial_out,
    input wire logic       data_request
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    int hi_cnt;
    int cmd_edges;
    int dat_edges;
    int req_cnt;
    // ****************************************
    // Phase and edge counters
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        hi_cnt    <= (rst_b && serial_clock) ? hi_cnt + 1 : 0;
        req_cnt   <= (rst_b && data_request) ? req_cnt + 1 : 0;
        cmd_edges <= (!rst_b || command_select_n) ? 0 : cmd_edges + int'($rose(serial_clock));
        dat_edges <= (!rst_b || data_select_n) ? 0 : dat_edges + int'($rose(serial_clock));
    end
    sequence gap_s;
        command_select_n[*8];
    endsequence
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    apb_err_a: assert property (psel && !penable && paddr > CDP_OFF_STATUS |=> pslverr)
        else $error("no error on unmapped offset");
    sclk_high_a: assert property ($fell(serial_clock) |-> hi_cnt == CDP_HALF_CYC)
        else $error("serial clock high phase wrong");
    cmd_bits_a: assert property ($rose(command_select_n) && cmd_edges != 0 |-> cmd_edges == 32)
        else $error("command frame not 32 bits");
    byte_bits_a: assert property ($rose(data_select_n) && dat_edges != 0 |-> dat_edges == 8)
        else $error("stream frame not 8 bits");
    req_gate_a: assert property ($fell(command_select_n) || $fell(data_select_n) |-> req_cnt >= 2)
        else $error("frame started without request");
    sel_excl_a: assert property (!command_select_n |-> data_select_n)
        else $error("both selects low");
    frame_gap_a: assert property ($rose(command_select_n) |-> gap_s)
        else $error("command select gap too short");
    mosi_hold_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_out))
        else $error("serial out changed while clock high");
    sel_steady_a: assert property (serial_clock |-> $stable(command_select_n) && $stable(data_select_n))
        else $error("select moved while clock high");
endmodule : cdp_host_sva
bind cdp_host cdp_host_sva u_sva
(
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .command_select_n(command_select_n),
    .data_select_n(data_select_n), .serial_clock(serial_clock), .serial_out(serial_out),
    .data_request(data_request)
);
`default_nettype wire

// ### dv/cdp_dev_model.sv
// Purpose: Behavioural model of the decoder's command and stream ports
// Assumes: Sampling on rising serial clock, mode set by the bench
// Notes:   Writes hold request low longer than reads; stall holds it low
`timescale 1ns/1ps
`default_nettype none
module cdp_dev_model
    import cdp_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // Link
    input  wire logic command_select_n,
    input  wire logic data_select_n,
    input  wire logic serial_clock,
    input  wire logic serial_out,
    output logic      serial_in,
    output logic      data_request,
    // Mode and knobs
    input  wire logic shared,
    input  wire logic lsbf,
    input  wire logic stall
);
    logic [15:0] regs [256];
    logic [7:0]  rx_q [$];
    logic [31:0] sh;
    logic [15:0] rdv;
    logic [7:0]  sb;
    logic        rd_on;
    int          nb;
    int          db;
    int          pend;
    int          hold;
    wire stream_sel = shared ? command_select_n : !data_select_n;
    initial
    begin
        serial_in = 1'b0;
        pend      = 0;
        hold      = 0;
    end
    always @(negedge command_select_n)
    begin
        nb    = 0;
        rd_on = 1'b0;
    end
    always @(negedge data_select_n)
        db = 0;
    always @(posedge serial_clock)
        if (!command_select_n)
        begin
            sh = {sh[30:0], serial_out};
            nb = nb + 1;
        end
        else if (stream_sel)
        begin
            sb = lsbf ? {serial_out, sb[7:1]} : {sb[6:0], serial_out};
            db = db + 1;
            if (db == 8)
            begin
                rx_q.push_back(sb);
                db = 0;
            end
        end
    always @(negedge serial_clock)
        if (!command_select_n && nb >= 16 && nb < 32)
        begin
            if (nb == 16)
            begin
                rdv   = regs[sh[7:0]];
                rd_on = (sh[15:8] == CDP_OP_READ);
            end
            if (rd_on)
                serial_in = rdv[31 - nb];
        end
    always @(posedge command_select_n)
    begin
        if (nb == 32 && sh[31:24] == CDP_OP_WRITE)
            regs[sh[23:16]] = sh[15:0];
        if (nb == 32)
            pend = (sh[31:24] == CDP_OP_WRITE) ? 60 : 3;
        if (shared)
            db = 0;
        serial_in = ~serial_in;
    end
    always @(posedge core_clk)
    begin
        if (pend > 0)
        begin
            hold = pend;
            pend = 0;
        end
        else if (hold > 0)
            hold = hold - 1;
        data_request <= rst_b && !stall && hold == 0;
    end
endmodule : cdp_dev_model
`default_nettype wire

// ### dv/tb_codec_serial_cmd_data_port.sv
// Purpose: Self-checking bench for the host controller with a device model
// Assumes: APB master in the bench, random addresses and data
// Notes:   Expected register contents kept in a bench array, stream contents in a bench queue
`timescale 1ns/1ps
`default_nettype none
module tb_codec_serial_cmd_data_port;
    import cdp_pkg::*;
    logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, busy, err;
    logic [7:0]  paddr, a;
    logic [31:0] pwdata, prdata, r, rnd, seed;
    logic        cs_n, ds_n, sclk, sout, sin, req, shared, lsbf, stall;
    logic [15:0] exp_reg [int];
    logic [7:0]  exp_q [$];
    int          failures, checks, i, j, n0;
    cdp_host DUT (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .command_select_n(cs_n), .data_select_n(ds_n),
        .serial_clock(sclk), .serial_out(sout), .serial_in(sin), .data_request(req),
        .busy(busy));
    cdp_dev_model dev (.core_clk(core_clk), .rst_b(rst_b), .command_select_n(cs_n),
        .data_select_n(ds_n), .serial_clock(sclk), .serial_out(sout), .serial_in(sin),
        .data_request(req), .shared(shared), .lsbf(lsbf), .stall(stall));
    always #10 core_clk = ~core_clk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic give_up(input string what);
        check(what, 32'h0000_0001, 32'h0000_0000);
        complete_run();
    endtask : give_up
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= ad;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            give_up("pready timeout");
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_idle();
        int n;
        // Busy rises one cycle after a job is queued
        repeat (2) @(posedge core_clk);
        for (n = 0; n < 4000 && busy !== 1'b0; n++)
            @(posedge core_clk);
        if (n == 4000)
            give_up("busy timeout");
    endtask : wait_idle
    task automatic send_byte(input logic [7:0] b);
        int n;
        for (n = 0; n < 2000; n++)
        begin
            apb(1'b0, CDP_OFF_STATUS, 32'h0000_0000);
            if (r[CDP_ST_SFULL] === 1'b0)
                break;
        end
        if (n == 2000)
            give_up("byte slot timeout");
        apb(1'b1, CDP_OFF_STREAM, {24'h00_0000, b});
        exp_q.push_back(b);
    endtask : send_byte
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {core_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {shared, lsbf, stall, failures, checks} = '0;
        seed = 32'h1526_bc13;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, CDP_OFF_CTRL, 32'h0000_0000);
        check("ctrl reset", CDP_CTRL_RESET, r);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, err});
        for (i = 0; i < 4; i++)
        begin
            rnd = $random(seed);
            a   = rnd[7:0];
            rnd = $random(seed);
            exp_reg[a] = rnd[15:0];
            apb(1'b1, CDP_OFF_WDATA, rnd);
            apb(1'b1, CDP_OFF_CMD, {23'h0, 1'b1, a});
            wait_idle();
            check("device register", {16'h0, exp_reg[a]}, {16'h0, dev.regs[a]});
            apb(1'b1, CDP_OFF_CMD, {24'h0, a});
            wait_idle();
            apb(1'b0, CDP_OFF_RDATA, 32'h0000_0000);
            check("read data", {16'h0, exp_reg[a]}, {16'h0, r[15:0]});
            apb(1'b0, CDP_OFF_STATUS, 32'h0000_0000);
            check("read done", 32'h0000_0001, {31'h0, r[CDP_ST_RDONE]});
        end
        for (i = 0; i < 3; i++)
        begin
            lsbf   = (i == 1);
            shared = (i == 2);
            apb(1'b1, CDP_OFF_CTRL, {30'h0, lsbf, shared});
            for (j = 0; j < 3; j++)
            begin
                rnd = $random(seed);
                send_byte(rnd[7:0]);
            end
            wait_idle();
        end
        stall <= 1'b1;
        repeat (10) @(posedge core_clk);
        n0 = dev.rx_q.size();
        send_byte(8'hA5);
        repeat (300) @(posedge core_clk);
        check("bytes while stalled", 32'(n0), 32'(dev.rx_q.size()));
        stall <= 1'b0;
        wait_idle();
        check("byte count", 32'(exp_q.size()), 32'(dev.rx_q.size()));
        for (i = 0; i < exp_q.size() && i < dev.rx_q.size(); i++)
            check("stream byte", {24'h0, exp_q[i]}, {24'h0, dev.rx_q[i]});
        complete_run();
    end
endmodule : tb_codec_serial_cmd_data_port
`default_nettype wire
